//--- hdl/ipc_pkg.sv
package ipc_pkg;

   // Register bus geometry
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;
   localparam int POS_W = 24;
   localparam int SEL_W = 5;
   localparam int PCT_W = 7;
   localparam int NUM_OUT = 4;
   localparam int DNUM_W = 6;

   // Register byte addresses
   localparam logic [ADDR_W-1:0] ADR_CTRL = 6'h00;
   localparam logic [ADDR_W-1:0] ADR_OSEL = 6'h04;
   localparam logic [ADDR_W-1:0] ADR_PRESET = 6'h08;
   localparam logic [ADDR_W-1:0] ADR_AREA1 = 6'h0c;
   localparam logic [ADDR_W-1:0] ADR_AREA2 = 6'h10;
   localparam logic [ADDR_W-1:0] ADR_ENCP = 6'h14;
   localparam logic [ADDR_W-1:0] ADR_CURR = 6'h18;
   localparam logic [ADDR_W-1:0] ADR_SER = 6'h1c;
   localparam logic [ADDR_W-1:0] ADR_STAT = 6'h20;

   // Field positions in the current register
   localparam int CUR_RUN_LSB = 0;
   localparam int CUR_STBY_LSB = 8;

   // Current percentages
   localparam logic [PCT_W-1:0] CUR_MIN = 7'h05;
   localparam logic [PCT_W-1:0] RUN_MAX = 7'h64;
   localparam logic [PCT_W-1:0] STBY_MAX = 7'h32;

   // Output selector codes
   localparam logic [SEL_W-1:0] SEL_AREA = 5'h05;
   localparam logic [SEL_W-1:0] SEL_TIM = 5'h06;
   localparam logic [SEL_W-1:0] SEL_READY = 5'h07;
   localparam logic [SEL_W-1:0] SEL_WARN = 5'h08;
   localparam logic [SEL_W-1:0] SEL_HOMEP = 5'h09;
   localparam logic [SEL_W-1:0] SEL_ZERO = 5'h0a;
   localparam logic [SEL_W-1:0] SEL_ROUT1 = 5'h0b;
   localparam logic [SEL_W-1:0] SEL_ROUT2 = 5'h0c;
   localparam logic [SEL_W-1:0] SEL_MISS = 5'h0d;
   localparam logic [SEL_W-1:0] SEL_HEAT = 5'h0e;
   localparam logic [SEL_W-1:0] SEL_ROUT3 = 5'h0f;
   localparam logic [SEL_W-1:0] SEL_ROUT4 = 5'h10;
   localparam logic [NUM_OUT-1:0][SEL_W-1:0] OSEL_RST = {5'h09, 5'h08, 5'h07, 5'h05};

   // Stop action codes
   localparam logic [1:0] STOP_IMM = 2'h0;
   localparam logic [1:0] STOP_DEC = 2'h1;

   // Configuration word, 16 bits
   typedef struct packed {
      logic ot_act;
      logic sensor_input_a_nc;
      logic home_sensor_input_nc;
      logic ls_nc;
      logic ot_en;
      logic awo_nc;
      logic dnum_src;
      logic hfr_src;
      logic exc_src;
      logic home_sel;
      logic con_inv;
      logic stop_nc;
      logic [1:0] stop_act;
      logic stop_en;
      logic start_src;
   } ipc_ctrl_type;
   localparam logic [15:0] CTRL_RST = 16'h0b97;

   // Serial command word, 16 bits
   typedef struct packed {
      logic [NUM_OUT-1:0] rout;
      logic [DNUM_W-1:0] dnum;
      logic reverse_request;
      logic forward_request;
      logic home;
      logic con;
      logic stop;
      logic start;
   } ipc_ser_type;

   // Discrete input pins
   typedef struct packed {
      logic start;
      logic stop;
      logic con;
      logic home;
      logic forward_request;
      logic reverse_request;
      logic [DNUM_W-1:0] dnum;
      logic current_off_input;
      logic ls_p;
      logic ls_n;
      logic home_sensor_input;
      logic sensor_input_a;
   } ipc_pin_type;

   // Status sources for the general outputs
   typedef struct packed {
      logic tim;
      logic ready;
      logic warn;
      logic homep;
      logic zero;
      logic miss;
      logic heat;
   } ipc_src_type;

   // Resolved commands toward the motion core, 22 bits
   typedef struct packed {
      logic start;
      logic stop;
      logic [1:0] stop_act;
      logic excite;
      logic home;
      logic preset;
      logic forward_request;
      logic reverse_request;
      logic [DNUM_W-1:0] dnum;
      logic current_off_input;
      logic ls_p;
      logic ls_n;
      logic home_sensor_input;
      logic sensor_input_a;
      logic ot;
      logic ot_act;
   } ipc_cmd_type;

endpackage

//--- hdl/ipc_io_config.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Start from serial at 0, pins at 1
// - Stop pin enable; serial stop always works
// - Two-bit stop action, decelerate by default
// - Stop pin polarity, normally closed default
// - Serial excitation polarity, zero means energise-off
// - Power-on excitation follows polarity setting
// - Four outputs, own selector each
// - Selector code to status function decode
// - Home pin is home or preset
// - Excitation from pin or serial link
// - Home, forward, reverse source select
// - Data number bits source select
// - Current-off input polarity, normally open default
// - Limit, home, sensor_input_a sensor polarities
// - Overtravel enable; limits always during homing
// - Overtravel stop immediate or decelerated
// - Signed 24-bit preset position held
// - In-area output between two bounds
// - Encoder preset held, used with encoder
// - Operating current 5 to 100 percent
// - Standstill current 5 to 50 percent
// - Link writes touch working copy only
module ipc_io_config
   import ipc_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire ipc_pin_type i_pin,
   input wire ipc_src_type i_src,
   input wire logic i_homing,
   input wire logic i_enc_fitted,
   input wire logic [POS_W-1:0] i_motor_pos,
   output logic [DATA_W-1:0] o_rdata,
   output ipc_cmd_type o_cmd,
   output logic [NUM_OUT-1:0] o_gen_out,
   output logic o_in_area,
   output logic [POS_W-1:0] o_preset_pos,
   output logic [POS_W-1:0] o_enc_preset,
   output logic o_enc_preset_vld,
   output logic [PCT_W-1:0] o_run_pct,
   output logic [PCT_W-1:0] o_stby_pct
);

   // Working copies of the parameters
   ipc_ctrl_type ctrl_r;
   logic [NUM_OUT-1:0][SEL_W-1:0] osel_r;
   logic [POS_W-1:0] preset_r;
   logic [POS_W-1:0] area1_r;
   logic [POS_W-1:0] area2_r;
   logic [POS_W-1:0] encp_r;
   logic [PCT_W-1:0] run_r;
   logic [PCT_W-1:0] stby_r;
   ipc_ser_type ser_r;

   // Output stage
   ipc_cmd_type cmd_r;
   ipc_cmd_type cmd_nxt;
   logic [NUM_OUT-1:0] gen_r;
   logic [NUM_OUT-1:0] gen_nxt;
   logic area_r;
   logic area_nxt;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;

   // Write decode
   wire logic wr_ctrl = i_wr && (i_addr == ADR_CTRL);
   wire logic wr_osel = i_wr && (i_addr == ADR_OSEL);
   wire logic wr_preset = i_wr && (i_addr == ADR_PRESET);
   wire logic wr_area1 = i_wr && (i_addr == ADR_AREA1);
   wire logic wr_area2 = i_wr && (i_addr == ADR_AREA2);
   wire logic wr_encp = i_wr && (i_addr == ADR_ENCP);
   wire logic wr_curr = i_wr && (i_addr == ADR_CURR);
   wire logic wr_ser = i_wr && (i_addr == ADR_SER);

   // Requested current values before clamping
   wire logic [PCT_W-1:0] run_req = i_wdata[CUR_RUN_LSB +: PCT_W];
   wire logic [PCT_W-1:0] stby_req = i_wdata[CUR_STBY_LSB +: PCT_W];

   // Clamp into the legal percentage windows
   wire logic [PCT_W-1:0] run_clip = (run_req < CUR_MIN) ? CUR_MIN :
                                     (run_req > RUN_MAX) ? RUN_MAX : run_req;
   wire logic [PCT_W-1:0] stby_clip = (stby_req < CUR_MIN) ? CUR_MIN :
                                      (stby_req > STBY_MAX) ? STBY_MAX : stby_req;

   // Parameter registers, working copy only
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         ctrl_r <= ipc_ctrl_type'(CTRL_RST);
         osel_r <= OSEL_RST;
         preset_r <= '0;
         area1_r <= '0;
         area2_r <= '0;
         encp_r <= '0;
         run_r <= RUN_MAX;
         stby_r <= STBY_MAX;
      end else begin
         // Bus writes land in volatile storage only
         if (wr_ctrl) begin
            ctrl_r <= ipc_ctrl_type'(i_wdata[15:0]);
         end
         if (wr_osel) begin
            osel_r <= i_wdata[NUM_OUT*SEL_W-1:0];
         end
         if (wr_preset) begin
            preset_r <= i_wdata[POS_W-1:0];
         end
         if (wr_area1) begin
            area1_r <= i_wdata[POS_W-1:0];
         end
         if (wr_area2) begin
            area2_r <= i_wdata[POS_W-1:0];
         end
         if (wr_encp) begin
            encp_r <= i_wdata[POS_W-1:0];
         end
         if (wr_curr) begin
            run_r <= run_clip;
            stby_r <= stby_clip;
         end
      end
   end

   // Serial command word; cleared at power-on
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         ser_r <= '0;
      end else if (wr_ser) begin
         ser_r <= ipc_ser_type'(i_wdata[15:0]);
      end
   end

   // Source selection between pins and the link
   wire logic start_sel = ctrl_r.start_src ? i_pin.start : ser_r.start;
   wire logic hfr_home = ctrl_r.hfr_src ? i_pin.home : ser_r.home;
   wire logic hfr_fwd = ctrl_r.hfr_src ? i_pin.forward_request : ser_r.forward_request;
   wire logic hfr_rvs = ctrl_r.hfr_src ? i_pin.reverse_request : ser_r.reverse_request;
   wire logic [DNUM_W-1:0] dnum_sel = ctrl_r.dnum_src ? i_pin.dnum : ser_r.dnum;

   // Stop: pin gated by its enable, link stop always honoured
   wire logic stop_pin_act = i_pin.stop ^ ctrl_r.stop_nc;
   wire logic stop_sel = (ctrl_r.stop_en && stop_pin_act) || ser_r.stop;

   // Excitation: link bit passes through the polarity setting
   wire logic con_ser = ser_r.con ^ ctrl_r.con_inv;
   wire logic excite_sel = ctrl_r.exc_src ? i_pin.con : con_ser;

   // Sensor inputs normalised to active high
   wire logic awo_act = i_pin.current_off_input ^ ctrl_r.awo_nc;
   wire logic ls_p_act = i_pin.ls_p ^ ctrl_r.ls_nc;
   wire logic ls_n_act = i_pin.ls_n ^ ctrl_r.ls_nc;
   wire logic home_sensor_input_act = i_pin.home_sensor_input ^ ctrl_r.home_sensor_input_nc;
   wire logic sensor_input_a_act = i_pin.sensor_input_a ^ ctrl_r.sensor_input_a_nc;

   // Limits count while enabled or while homing
   wire logic ot_arm = ctrl_r.ot_en || i_homing;
   wire logic ot_hit = ot_arm && (ls_p_act || ls_n_act);

   // Assemble the command word
   always_comb begin
      cmd_nxt = '0;
      cmd_nxt.start = start_sel;
      cmd_nxt.stop = stop_sel;
      cmd_nxt.stop_act = ctrl_r.stop_act;
      cmd_nxt.excite = excite_sel;
      // Shared pin: home request or preset request
      cmd_nxt.home = hfr_home && !ctrl_r.home_sel;
      cmd_nxt.preset = hfr_home && ctrl_r.home_sel;
      cmd_nxt.forward_request = hfr_fwd;
      cmd_nxt.reverse_request = hfr_rvs;
      cmd_nxt.dnum = dnum_sel;
      cmd_nxt.current_off_input = awo_act;
      cmd_nxt.ls_p = ls_p_act;
      cmd_nxt.ls_n = ls_n_act;
      cmd_nxt.home_sensor_input = home_sensor_input_act;
      cmd_nxt.sensor_input_a = sensor_input_a_act;
      cmd_nxt.ot = ot_hit;
      cmd_nxt.ot_act = ctrl_r.ot_act;
   end

   // Area bounds ordered so either register may hold the larger
   wire logic a1_big = $signed(area1_r) > $signed(area2_r);
   wire logic [POS_W-1:0] area_lo = a1_big ? area2_r : area1_r;
   wire logic [POS_W-1:0] area_hi = a1_big ? area1_r : area2_r;

   // Inclusive signed window compare
   assign area_nxt = ($signed(i_motor_pos) >= $signed(area_lo)) &&
                     ($signed(i_motor_pos) <= $signed(area_hi));

   // Function vector indexed by selector code
   logic [31:0] fn_vec;
   always_comb begin
      fn_vec = '0;
      fn_vec[SEL_AREA] = area_r;
      fn_vec[SEL_TIM] = i_src.tim;
      fn_vec[SEL_READY] = i_src.ready;
      fn_vec[SEL_WARN] = i_src.warn;
      fn_vec[SEL_HOMEP] = i_src.homep;
      // Encoder-based signals only with an encoder fitted
      fn_vec[SEL_ZERO] = i_src.zero && i_enc_fitted;
      fn_vec[SEL_ROUT1] = ser_r.rout[0];
      fn_vec[SEL_ROUT2] = ser_r.rout[1];
      fn_vec[SEL_MISS] = i_src.miss && i_enc_fitted;
      fn_vec[SEL_HEAT] = i_src.heat;
      fn_vec[SEL_ROUT3] = ser_r.rout[2];
      fn_vec[SEL_ROUT4] = ser_r.rout[3];
   end

   // One selector per general output
   genvar g;
   generate
      for (g = 0; g < NUM_OUT; g++) begin : g_out
         assign gen_nxt[g] = fn_vec[osel_r[g]];
      end
   endgenerate

   // Status word for software
   wire logic [DATA_W-1:0] stat_word = {5'h00, area_r, gen_r, cmd_r};

   // Read mux; unmapped addresses read zero
   always_comb begin
      unique case (i_addr)
         ADR_CTRL: rdata_nxt = {16'h0000, ctrl_r};
         ADR_OSEL: rdata_nxt = {12'h000, osel_r};
         ADR_PRESET: rdata_nxt = {{8{preset_r[POS_W-1]}}, preset_r};
         ADR_AREA1: rdata_nxt = {{8{area1_r[POS_W-1]}}, area1_r};
         ADR_AREA2: rdata_nxt = {{8{area2_r[POS_W-1]}}, area2_r};
         ADR_ENCP: rdata_nxt = {{8{encp_r[POS_W-1]}}, encp_r};
         ADR_CURR: rdata_nxt = {17'h00000, stby_r, 1'b0, run_r};
         ADR_SER: rdata_nxt = {16'h0000, ser_r};
         ADR_STAT: rdata_nxt = stat_word;
         default: rdata_nxt = '0;
      endcase
   end

   // Registered outputs
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         cmd_r <= '0;
         gen_r <= '0;
         area_r <= 1'b0;
         rdata_r <= '0;
      end else begin
         cmd_r <= cmd_nxt;
         gen_r <= gen_nxt;
         area_r <= area_nxt;
         // Read data only in the cycle after the strobe
         rdata_r <= i_rd ? rdata_nxt : '0;
      end
   end

   assign o_rdata = rdata_r;
   assign o_cmd = cmd_r;
   assign o_gen_out = gen_r;
   assign o_in_area = area_r;
   assign o_preset_pos = preset_r;
   assign o_enc_preset = encp_r;
   assign o_run_pct = run_r;
   assign o_stby_pct = stby_r;

   // Encoder preset flagged usable only with an encoder
   logic encv_r;
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         encv_r <= 1'b0;
      end else begin
         encv_r <= i_enc_fitted;
      end
   end
   assign o_enc_preset_vld = encv_r;

   // Checks
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_srst);

   // Write then read of the configuration word
   sequence ctrl_write_s;
      wr_ctrl;
   endsequence
   sequence ctrl_read_s;
      i_rd && (i_addr == ADR_CTRL);
   endsequence

   start_source_a: assert property (
      !ctrl_r.start_src |=> o_cmd.start == $past(ser_r.start))
      else $error("start source select wrong");

   start_pin_a: assert property (
      ctrl_r.start_src |=> o_cmd.start == $past(i_pin.start))
      else $error("start pin select wrong");

   stop_gate_a: assert property (
      (!ctrl_r.stop_en && !ser_r.stop) |=> !o_cmd.stop)
      else $error("stop pin not gated");

   stop_polarity_a: assert property (
      (ctrl_r.stop_en && (i_pin.stop != ctrl_r.stop_nc)) |=> o_cmd.stop)
      else $error("stop polarity wrong");

   serial_excite_a: assert property (
      (!ctrl_r.exc_src && !ctrl_r.con_inv) |=> o_cmd.excite == $past(ser_r.con))
      else $error("serial excitation wrong");

   serial_invert_a: assert property (
      (!ctrl_r.exc_src && ctrl_r.con_inv) |=> o_cmd.excite != $past(ser_r.con))
      else $error("inverted excitation wrong");

   excite_pin_a: assert property (
      ctrl_r.exc_src |=> o_cmd.excite == $past(i_pin.con))
      else $error("pin excitation wrong");

   output_select_a: assert property (
      (osel_r[1] == SEL_READY) |=> o_gen_out[1] == $past(i_src.ready))
      else $error("output select decode wrong");

   area_window_a: assert property (
      (($signed(i_motor_pos) >= $signed(area1_r) && $signed(i_motor_pos) <= $signed(area2_r)) ||
       ($signed(i_motor_pos) >= $signed(area2_r) && $signed(i_motor_pos) <= $signed(area1_r)))
      |=> o_in_area)
      else $error("in-area not asserted");

   area_out_a: assert property (
      (($signed(i_motor_pos) < $signed(area1_r) || $signed(i_motor_pos) > $signed(area2_r)) &&
       ($signed(i_motor_pos) < $signed(area2_r) || $signed(i_motor_pos) > $signed(area1_r)))
      |=> !o_in_area)
      else $error("in-area outside bounds");

   homing_limit_a: assert property (
      (i_homing && (i_pin.ls_p != ctrl_r.ls_nc)) |=> o_cmd.ot)
      else $error("limit ignored during homing");

   current_range_a: assert property (
      o_run_pct >= CUR_MIN && o_run_pct <= RUN_MAX &&
      o_stby_pct >= CUR_MIN && o_stby_pct <= STBY_MAX)
      else $error("current out of range");

   ctrl_readback_a: assert property (
      ctrl_write_s ##1 ctrl_read_s |=> o_rdata[15:0] == $past(i_wdata[15:0], 2))
      else $error("config readback wrong");

   stop_action_a: assert property (
      1'b1 |=> o_cmd.stop_act == $past(ctrl_r.stop_act))
      else $error("stop action not passed on");

   home_switch_a: assert property (
      (ctrl_r.hfr_src && i_pin.home) |=> (o_cmd.preset != o_cmd.home) &&
         (o_cmd.preset == $past(ctrl_r.home_sel)))
      else $error("home or preset switch wrong");

   limit_gate_a: assert property (
      (!ctrl_r.ot_en && !i_homing) |=> !o_cmd.ot)
      else $error("overtravel not gated");

   ot_action_a: assert property (
      1'b1 |=> o_cmd.ot_act == $past(ctrl_r.ot_act))
      else $error("overtravel action not passed on");

   dnum_source_a: assert property (
      !ctrl_r.dnum_src |=> o_cmd.dnum == $past(ser_r.dnum))
      else $error("data number source wrong");

   awo_polarity_a: assert property (
      1'b1 |=> o_cmd.current_off_input == ($past(i_pin.current_off_input) ^ $past(ctrl_r.awo_nc)))
      else $error("current-off polarity wrong");

   // Read data stands only in the cycle after a read strobe
   read_idle_a: assert property (
      !i_rd |=> o_rdata == '0)
      else $error("read data outside its cycle");

endmodule

`default_nettype wire

//--- tb/ipc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host controller side: discrete pins, status levels and motor position
module ipc_host_model
   import ipc_pkg::*;
(
   input wire logic i_clk_sys,
   output var ipc_pin_type o_pin,
   output var ipc_src_type o_src,
   output logic [POS_W-1:0] o_pos,
   output logic o_homing,
   output logic o_enc_fitted
);

   // Quiet levels until the bench asks for more
   initial begin
      o_pin = '0;
      o_src = '0;
      o_pos = '0;
      o_homing = 1'b0;
      o_enc_fitted = 1'b0;
   end

   // All levels move together just after a rising edge
   task automatic drive(input ipc_pin_type p, input ipc_src_type s,
      input logic [POS_W-1:0] pos, input logic hm, input logic enc);
      @(posedge i_clk_sys);
      o_pin <= p;
      o_src <= s;
      o_pos <= pos;
      o_homing <= hm;
      o_enc_fitted <= enc;
   endtask

endmodule

`default_nettype wire

//--- tb/ipc_io_config_tb.sv
`timescale 1ns/1ps
`default_nettype none

module ipc_io_config_tb
   import ipc_pkg::*;
;
   // Bus side, driven by the bench
   logic i_clk_sys = 1'b0;
   logic i_srst = 1'b1;
   logic [ADDR_W-1:0] i_addr = '0;
   logic [DATA_W-1:0] i_wdata = '0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   // Host to block wiring
   wire ipc_pin_type pin_w;
   wire ipc_src_type src_w;
   wire logic [POS_W-1:0] pos_w;
   wire logic hm_w;
   wire logic enc_w;
   // Block outputs
   logic [DATA_W-1:0] o_rdata;
   ipc_cmd_type o_cmd;
   logic [NUM_OUT-1:0] o_gen_out;
   logic o_in_area;
   logic [POS_W-1:0] o_preset_pos;
   logic [POS_W-1:0] o_enc_preset;
   logic o_enc_preset_vld;
   logic [PCT_W-1:0] o_run_pct;
   logic [PCT_W-1:0] o_stby_pct;
   // Bench state
   ipc_pin_type pin = '0;
   ipc_src_type src = '0;
   logic [POS_W-1:0] pos = '0;
   logic hm = 1'b0;
   logic enc = 1'b0;
   ipc_ctrl_type ctl;
   ipc_ser_type ser;
   int errors = 0;
   int check_count = 0;
   // Stimulus tables
   logic [POS_W-1:0] apos [5] = '{24'hffff9c, 24'h000064, 24'h000065, 24'hffff9b, 24'h000000};
   logic [4:0] aexp = 5'b10011;
   logic [15:0] cw [5] = '{16'h7f00, 16'h0465, 16'h1425, 16'h3305, 16'h0504};
   logic [15:0] ce [5] = '{16'h3205, 16'h0564, 16'h1425, 16'h3205, 16'h0505};
   logic [15:0] cfg [6] = '{16'h0b97, 16'hf468, 16'h0000, 16'hffff, 16'h5a3c, 16'ha5c3};
   logic [16:0] pp [4] = '{17'h00000, 17'h1ffff, 17'h0a5a5, 17'h15a5a};
   logic [15:0] sp [4] = '{16'h0000, 16'hffff, 16'h5a5a, 16'ha5a5};

   // 10 MHz system clock
   always #50 i_clk_sys = ~i_clk_sys;

   ipc_io_config DUT (
      .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .i_pin(pin_w), .i_src(src_w), .i_homing(hm_w),
      .i_enc_fitted(enc_w), .i_motor_pos(pos_w), .o_rdata(o_rdata), .o_cmd(o_cmd),
      .o_gen_out(o_gen_out), .o_in_area(o_in_area), .o_preset_pos(o_preset_pos),
      .o_enc_preset(o_enc_preset), .o_enc_preset_vld(o_enc_preset_vld),
      .o_run_pct(o_run_pct), .o_stby_pct(o_stby_pct));

   ipc_host_model host (
      .i_clk_sys(i_clk_sys), .o_pin(pin_w), .o_src(src_w), .o_pos(pos_w),
      .o_homing(hm_w), .o_enc_fitted(enc_w));

   // Compare and count
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge i_clk_sys);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask

   // One-cycle read strobe, data looked at in the following cycle only
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge i_clk_sys);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1;
      check(o_rdata, exp);
   endtask

   // Write strobe followed at once by a read strobe of the same place
   task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      input logic [DATA_W-1:0] exp);
      @(posedge i_clk_sys);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1;
      check(o_rdata, exp);
   endtask

   // Hand levels to the host, then let the registered outputs follow
   task automatic apply();
      host.drive(pin, src, pos, hm, enc);
      repeat (2) @(posedge i_clk_sys);
      #1;
   endtask

   // Expected command word from configuration, link word and pins
   function automatic ipc_cmd_type ref_cmd(input ipc_ctrl_type c, input ipc_ser_type s,
      input ipc_pin_type p, input logic h);
      ipc_cmd_type e;
      logic hreq;
      e.start = c.start_src ? p.start : s.start;
      e.stop = ((p.stop ^ c.stop_nc) & c.stop_en) | s.stop;
      e.stop_act = c.stop_act;
      e.excite = c.exc_src ? p.con : (s.con ^ c.con_inv);
      hreq = c.hfr_src ? p.home : s.home;
      e.home = hreq & ~c.home_sel;
      e.preset = hreq & c.home_sel;
      e.forward_request = c.hfr_src ? p.forward_request : s.forward_request;
      e.reverse_request = c.hfr_src ? p.reverse_request : s.reverse_request;
      e.dnum = c.dnum_src ? p.dnum : s.dnum;
      e.current_off_input = p.current_off_input ^ c.awo_nc;
      e.ls_p = p.ls_p ^ c.ls_nc;
      e.ls_n = p.ls_n ^ c.ls_nc;
      e.home_sensor_input = p.home_sensor_input ^ c.home_sensor_input_nc;
      e.sensor_input_a = p.sensor_input_a ^ c.sensor_input_a_nc;
      e.ot = (e.ls_p | e.ls_n) & (c.ot_en | h);
      e.ot_act = c.ot_act;
      return e;
   endfunction

   // Verdict and end of run
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (60000) @(posedge i_clk_sys);
      errors++;
      stop_test();
   end

   // Main sequence
   initial begin
      logic [11:0] v;
      repeat (15) @(posedge i_clk_sys);
      #1;
      check(32'(o_run_pct), 32'h64);
      check(32'(o_stby_pct), 32'h32);
      @(posedge i_clk_sys);
      i_srst <= 1'b0;
      // Reset contents and unmapped places
      rd(ADR_CTRL, 32'h0b97);
      rd(ADR_OSEL, 32'h0004a0e5);
      rd(ADR_CURR, 32'h00003264);
      rd(ADR_AREA1, 32'h0);
      rd(ADR_AREA2, 32'h0);
      wr(6'h24, 32'hffffffff);
      rd(6'h24, 32'h0);
      // Reset selectors: area, ready, warning, home position
      src = 7'b1010001;
      apply();
      check(32'(o_gen_out), 32'h5);
      // Selector codes 4 to 17, target alone low then target alone high
      enc = 1'b1;
      for (int k = 4; k <= 17; k++) begin
         wr(ADR_OSEL, 32'({4{5'(k)}}));
         for (int p = 0; p < 2; p++) begin
            v = (k >= 5 && k <= 16) ? (12'h001 << (k - 5)) : 12'h000;
            if (p == 0) begin
               v = ~v;
            end
            pos = v[0] ? 24'h000000 : 24'h000005;
            src = {v[1], v[2], v[3], v[4], v[5], v[8], v[9]};
            wr(ADR_SER, 32'({v[11], v[10], v[7], v[6]}) << 12);
            apply();
            check(32'(o_gen_out), (p == 1 && k >= 5 && k <= 16) ? 32'hf : 32'h0);
         end
      end
      // Window with bounds given high first
      wr(ADR_AREA1, 32'h00000064);
      wr(ADR_AREA2, 32'hffffff9c);
      rd(ADR_AREA2, 32'hffffff9c);
      for (int i = 0; i < 5; i++) begin
         pos = apos[i];
         apply();
         check(32'(o_in_area), 32'(aexp[i]));
      end
      // Preset at both ends of the signed range
      wr(ADR_PRESET, 32'h00800000);
      #1;
      check(32'(o_preset_pos), 32'h00800000);
      rd(ADR_PRESET, 32'hff800000);
      wr(ADR_PRESET, 32'h007fffff);
      rd(ADR_PRESET, 32'h007fffff);
      // Encoder preset and its valid flag
      wr(ADR_ENCP, 32'hab7fffff);
      rd(ADR_ENCP, 32'h007fffff);
      check(32'({o_enc_preset_vld, o_enc_preset}), 32'h017fffff);
      enc = 1'b0;
      apply();
      check(32'(o_enc_preset_vld), 32'h0);
      // Current limits at and beyond the bounds
      for (int i = 0; i < 5; i++) begin
         wr(ADR_CURR, 32'(cw[i]));
         rd(ADR_CURR, 32'(ce[i]));
         check(32'({1'b0, o_stby_pct, 1'b0, o_run_pct}), 32'(ce[i]));
      end
      // Command resolution over configurations, pins and link words
      for (int c = 0; c < 6; c++) begin
         ctl = ipc_ctrl_type'(cfg[c]);
         // Read straight after the write must see the new word
         wr_rd(ADR_CTRL, 32'(ctl), 32'(cfg[c]));
         for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 4; j++) begin
               ser = ipc_ser_type'(sp[j]);
               wr(ADR_SER, 32'(ser));
               pin = ipc_pin_type'(pp[i]);
               hm = i[0] ^ j[0];
               apply();
               check(32'(o_cmd), 32'(ref_cmd(ctl, ser, pin, hm)));
               // Status word: in area at zero, all outputs on code 17
               rd(ADR_STAT, {5'h00, 1'b1, 4'h0, ref_cmd(ctl, ser, pin, hm)});
            end
         end
      end
      stop_test();
   end

endmodule

`default_nettype wire
